// [design/tcc_capture_compare.sv]
// Purpose: input capture and two compare units beside a 16-bit counter
// Assumes: counter, prescaler and pin muxing live outside; timer_tick
//          is a one-cycle pulse per timer clock on mclk
// Notes: 16-bit registers go through one shared high-byte latch
//
// Decided for this implementation: the register addresses and the address-and-strobe port.

// Summary of operation
// [RULE1] qualified edge copies counter into capture register
// [RULE2] capture flag set with copy; ack or write-one clears
// [RULE3] capture low read loads latch; high reads latch
// [RULE4] capture writable only when it sets TOP
// [RULE5] trigger from pin, or comparator when selected
// [RULE6] software clears capture flag after source change
// [RULE7] filter changes output after four equal samples
// [RULE8] filter enable bit, sampled on system clock
// [RULE9] capture disabled in capture-as-TOP modes
// [RULE10] new capture overwrites, no overrun protection
// [RULE11] software flips edge then clears flag
// [RULE12] compare all bits; flag at next timer tick
// [RULE13] compare flag irq when enabled; ack clears
// [RULE14] compare A value offered as counter TOP
// [RULE15] compare double buffered in PWM modes only
// [RULE16] access buffer when buffered; reads skip latch
// [RULE17] high byte to latch, low write moves both
// [RULE18] force strobe updates output outside PWM modes only, no flag
// [RULE19] counter write blocks matches next timer tick
// [RULE20] software avoids writing counter equal TOP
// [RULE21] output state kept across mode changes
// [RULE22] output mode field takes effect at once
// [RULE23] one high-byte latch for all 16-bit registers
// [RULE24] counter write beats clear or count
// [RULE25] edge select picks rising or falling edge
module tcc_capture_compare (
  input wire logic mclk, // system clock, 125 MHz
  input wire logic rstn, // synchronous reset, active low
  input wire logic [3:0] reg_addr, // register offset
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic [15:0] count_value, // counter value
  input wire logic timer_tick, // one pulse per timer clock
  input wire logic count_at_top, // counter is at TOP
  input wire logic count_at_bottom, // counter is at BOTTOM
  output logic count_wr, // counter load pulse
  output logic [15:0] count_wr_data, // counter load value
  input wire logic capture_in_pin, // asynchronous capture pin
  input wire logic comparator_out, // asynchronous comparator output
  input wire logic capture_irq_ack, // capture interrupt serviced
  input wire logic [1:0] compare_irq_ack, // compare irq serviced, B:A
  output logic capture_irq, // capture interrupt request
  output logic [1:0] compare_irq, // compare irq requests, B:A
  output logic [1:0] compare_match, // match pulses to waveforms, B:A
  output logic [1:0] compare_out_state, // output compare state, B:A
  output logic [15:0] compare_top_a, // compare A value as TOP
  output logic [15:0] capture_top, // capture value as TOP
  output logic [3:0] wave_gen_mode, // waveform generation mode
  output logic [2:0] clock_sel, // prescaler clock select
  output logic [1:0] compare_out_mode_a, // unit A output mode
  output logic [1:0] compare_out_mode_b // unit B output mode
);

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic comparator_capture_sel;
    logic [7:0] irq_en;
    logic [7:0] temp;
    logic [15:0] capture_value;
    logic capture_flag;
    logic [1:0][15:0] compare_value;
    logic [1:0][15:0] compare_buf;
    logic [1:0] compare_flag;
    logic [1:0] oc_state;
    logic [1:0] match;
    logic block;
    logic [2:0] sync_pin;
    logic [2:0] sync_cmp;
    logic lvl_pin;
    logic lvl_cmp;
    logic [tcc_pkg::FILT_LEN-1:0] filt_hist;
    logic filt_out;
    logic trig_prev;
    logic cnt_wr;
    logic [15:0] cnt_wr_val;
    logic [7:0] rdata;
  } tcc_state_s;

  tcc_state_s st_q;
  tcc_state_s st_d;

  logic [3:0] wgm;
  logic pwm_mode;
  logic cap_is_top;
  logic at_bottom_mode;
  logic wr_hit;
  logic rd_hit;
  logic trig_raw;
  logic trig;
  logic cap_edge;
  logic [1:0] com [2];

  // mode decode, shared by capture and compare paths
  assign wgm = {st_q.ctrl_b[tcc_pkg::WGM_HI_LSB +: 2],
                st_q.ctrl_a[tcc_pkg::WGM_LO_LSB +: 2]};
  assign pwm_mode = !(wgm == tcc_pkg::WGM_NORMAL ||
                      wgm == tcc_pkg::WGM_CTC_A ||
                      wgm == tcc_pkg::WGM_CTC_CAP ||
                      wgm == tcc_pkg::WGM_RSVD);
  assign cap_is_top = (wgm == tcc_pkg::WGM_PFC_CAP ||
                       wgm == tcc_pkg::WGM_PC_CAP ||
                       wgm == tcc_pkg::WGM_CTC_CAP ||
                       wgm == tcc_pkg::WGM_FAST_CAP);
  assign at_bottom_mode = (wgm == tcc_pkg::WGM_PFC_CAP ||
                           wgm == tcc_pkg::WGM_PFC_A);
  assign wr_hit = reg_wr;
  assign rd_hit = reg_rd;
  assign com[0] = st_q.ctrl_a[tcc_pkg::COM_A_LSB +: 2]; // see [RULE22]
  assign com[1] = st_q.ctrl_a[tcc_pkg::COM_B_LSB +: 2]; // see [RULE22]

  // trigger select and edge detection on the settled level
  assign trig_raw = st_q.comparator_capture_sel ? st_q.lvl_cmp
                                                : st_q.lvl_pin; // see [RULE5]
  assign trig = st_q.ctrl_b[tcc_pkg::FILT_EN_BIT] ? st_q.filt_out
                                                  : trig_raw; // see [RULE8]
  assign cap_edge = !cap_is_top &&                            // see [RULE9]
                    (st_q.ctrl_b[tcc_pkg::EDGE_SEL_BIT] ?
                     (trig && !st_q.trig_prev) :
                     (!trig && st_q.trig_prev));              // see [RULE25]

  // next-state logic for the whole block
  always_comb begin
    logic [15:0] wr_word;
    logic [1:0] forced;
    logic clr_cap;
    logic [1:0] clr_cmp;
    wr_word = {st_q.temp, reg_wdata};
    forced = 2'h0;
    clr_cap = 1'b0;
    clr_cmp = 2'h0;
    st_d = st_q;
    st_d.cnt_wr = 1'b0;
    st_d.match = 2'h0;
    st_d.rdata = tcc_pkg::RST_BYTE;

    // input synchronisers: a level counts once stages two and three agree
    st_d.sync_pin = {st_q.sync_pin[1:0], capture_in_pin};
    st_d.sync_cmp = {st_q.sync_cmp[1:0], comparator_out};
    if (st_q.sync_pin[2] == st_q.sync_pin[1]) begin
      st_d.lvl_pin = st_q.sync_pin[2];
    end
    if (st_q.sync_cmp[2] == st_q.sync_cmp[1]) begin
      st_d.lvl_cmp = st_q.sync_cmp[2];
    end

    // four-sample filter on every system clock
    st_d.filt_hist = {st_q.filt_hist[tcc_pkg::FILT_LEN-2:0], trig_raw};
    if (&st_d.filt_hist) begin                       // see [RULE7]
      st_d.filt_out = 1'b1;
    end else if (~|st_d.filt_hist) begin             // see [RULE7]
      st_d.filt_out = 1'b0;
    end
    st_d.trig_prev = trig;

    // register writes
    if (wr_hit) begin
      unique case (reg_addr)
        tcc_pkg::OFF_CTRL_A: st_d.ctrl_a = reg_wdata;
        tcc_pkg::OFF_CTRL_B: st_d.ctrl_b = reg_wdata;
        tcc_pkg::OFF_FORCE: begin
          if (!pwm_mode) begin                        // see [RULE18]
            forced[0] = reg_wdata[tcc_pkg::FORCE_A_BIT];
            forced[1] = reg_wdata[tcc_pkg::FORCE_B_BIT];
          end
        end
        tcc_pkg::OFF_CMP_CTRL: begin
          st_d.comparator_capture_sel = reg_wdata[tcc_pkg::CMP_CAP_SEL_BIT];
        end
        tcc_pkg::OFF_CNT_LO: begin
          st_d.cnt_wr = 1'b1;                         // see [RULE24]
          st_d.cnt_wr_val = wr_word;
          st_d.block = 1'b1;                          // see [RULE19]
        end
        tcc_pkg::OFF_CAP_LO: begin
          if (cap_is_top) begin                       // see [RULE4]
            st_d.capture_value = wr_word;
          end
        end
        tcc_pkg::OFF_CMPA_LO, tcc_pkg::OFF_CMPB_LO: begin
          if (pwm_mode) begin                         // see [RULE16]
            st_d.compare_buf[reg_addr[1]] = wr_word;  // see [RULE17]
          end else begin
            st_d.compare_value[reg_addr[1]] = wr_word; // see [RULE17]
          end
        end
        tcc_pkg::OFF_CNT_HI, tcc_pkg::OFF_CAP_HI,
        tcc_pkg::OFF_CMPA_HI, tcc_pkg::OFF_CMPB_HI: begin
          st_d.temp = reg_wdata;                      // see [RULE23]
        end
        tcc_pkg::OFF_IRQ_EN: st_d.irq_en = reg_wdata;
        tcc_pkg::OFF_FLAGS: begin
          clr_cap = reg_wdata[tcc_pkg::CAP_BIT];      // see [RULE2]
          clr_cmp[0] = reg_wdata[tcc_pkg::CMPA_BIT];  // see [RULE13]
          clr_cmp[1] = reg_wdata[tcc_pkg::CMPB_BIT];
        end
        default: begin
        end
      endcase
    end

    // register reads, answered one cycle later
    if (rd_hit) begin
      unique case (reg_addr)
        tcc_pkg::OFF_CTRL_A: st_d.rdata = st_q.ctrl_a;
        tcc_pkg::OFF_CTRL_B: st_d.rdata = st_q.ctrl_b;
        tcc_pkg::OFF_CMP_CTRL: begin
          st_d.rdata[tcc_pkg::CMP_CAP_SEL_BIT] = st_q.comparator_capture_sel;
        end
        tcc_pkg::OFF_CNT_LO: begin
          st_d.rdata = count_value[7:0];
          st_d.temp = count_value[15:8];              // see [RULE23]
        end
        tcc_pkg::OFF_CAP_LO: begin
          st_d.rdata = st_q.capture_value[7:0];
          st_d.temp = st_q.capture_value[15:8];       // see [RULE3]
        end
        tcc_pkg::OFF_CNT_HI, tcc_pkg::OFF_CAP_HI: begin
          st_d.rdata = st_q.temp;                     // see [RULE3]
        end
        tcc_pkg::OFF_CMPA_LO, tcc_pkg::OFF_CMPB_LO: begin
          st_d.rdata = pwm_mode ? st_q.compare_buf[reg_addr[1]][7:0]
                                : st_q.compare_value[reg_addr[1]][7:0];
        end
        tcc_pkg::OFF_CMPA_HI, tcc_pkg::OFF_CMPB_HI: begin
          st_d.rdata = pwm_mode ? st_q.compare_buf[reg_addr[1]][15:8]
                                : st_q.compare_value[reg_addr[1]][15:8];
        end                                           // see [RULE16]
        tcc_pkg::OFF_IRQ_EN: st_d.rdata = st_q.irq_en;
        tcc_pkg::OFF_FLAGS: begin
          st_d.rdata[tcc_pkg::CAP_BIT] = st_q.capture_flag;
          st_d.rdata[tcc_pkg::CMPA_BIT] = st_q.compare_flag[0];
          st_d.rdata[tcc_pkg::CMPB_BIT] = st_q.compare_flag[1];
        end
        default: st_d.rdata = tcc_pkg::RST_BYTE;
      endcase
    end

    // capture: copy counter and raise flag together, set beats clear
    if (capture_irq_ack || clr_cap) begin
      st_d.capture_flag = 1'b0;
    end
    if (cap_edge) begin
      st_d.capture_value = count_value;               // see [RULE1]
      st_d.capture_flag = 1'b1;                       // see [RULE2]
    end                                               // see [RULE10]

    // compare units: match, flag, buffer transfer and output state
    for (int i = 0; i < 2; i++) begin
      if (compare_irq_ack[i] || clr_cmp[i]) begin
        st_d.compare_flag[i] = 1'b0;
      end
      if (timer_tick && !st_q.block &&
          count_value == st_q.compare_value[i]) begin // see [RULE12]
        st_d.match[i] = 1'b1;
        st_d.compare_flag[i] = 1'b1;                  // see [RULE13]
        if (pwm_mode) begin
          if (com[i] == tcc_pkg::COM_CLEAR) begin
            st_d.oc_state[i] = 1'b0;
          end else if (com[i] == tcc_pkg::COM_SET) begin
            st_d.oc_state[i] = 1'b1;
          end
        end
      end
      if (forced[i] || st_d.match[i] && !pwm_mode) begin
        unique case (com[i])                          // see [RULE18]
          tcc_pkg::COM_TOGGLE: st_d.oc_state[i] = !st_q.oc_state[i];
          tcc_pkg::COM_CLEAR: st_d.oc_state[i] = 1'b0;
          tcc_pkg::COM_SET: st_d.oc_state[i] = 1'b1;
          default: st_d.oc_state[i] = st_q.oc_state[i]; // see [RULE21]
        endcase
      end
      if (pwm_mode && timer_tick && count_at_bottom &&
          !(st_d.match[i])) begin
        if (com[i] == tcc_pkg::COM_CLEAR) begin
          st_d.oc_state[i] = 1'b1;
        end else if (com[i] == tcc_pkg::COM_SET) begin
          st_d.oc_state[i] = 1'b0;
        end
      end
      if (pwm_mode && timer_tick &&
          (at_bottom_mode ? count_at_bottom : count_at_top)) begin
        st_d.compare_value[i] = st_q.compare_buf[i];  // see [RULE15]
      end
    end

    // a blocked timer tick consumes the block
    if (timer_tick && st_q.block) begin
      st_d.block = 1'b0;                              // see [RULE19]
    end
    if (wr_hit && reg_addr == tcc_pkg::OFF_CNT_LO) begin
      st_d.block = 1'b1;
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs
  assign reg_rdata = st_q.rdata;
  assign count_wr = st_q.cnt_wr;
  assign count_wr_data = st_q.cnt_wr_val;
  assign capture_irq = st_q.capture_flag && st_q.irq_en[tcc_pkg::CAP_BIT];
  assign compare_irq[0] = st_q.compare_flag[0] &&
                          st_q.irq_en[tcc_pkg::CMPA_BIT];
  assign compare_irq[1] = st_q.compare_flag[1] &&
                          st_q.irq_en[tcc_pkg::CMPB_BIT];
  assign compare_match = st_q.match;
  assign compare_out_state = st_q.oc_state;
  assign compare_top_a = st_q.compare_value[0];       // see [RULE14]
  assign capture_top = st_q.capture_value;
  assign wave_gen_mode = wgm;
  assign clock_sel = st_q.ctrl_b[tcc_pkg::CLK_SEL_LSB +: 3];
  assign compare_out_mode_a = com[0];
  assign compare_out_mode_b = com[1];

endmodule

// [shared/tcc_pkg.sv]
// Purpose: constants shared by the timer capture/compare block
// Assumes: 8-bit register port, byte offsets below
// Notes: offsets are register indices on the plain port
package tcc_pkg;
  // register offsets
  localparam logic [3:0] OFF_CTRL_A = 4'h0;
  localparam logic [3:0] OFF_CTRL_B = 4'h1;
  localparam logic [3:0] OFF_FORCE = 4'h2;
  localparam logic [3:0] OFF_CMP_CTRL = 4'h3;
  localparam logic [3:0] OFF_CNT_LO = 4'h4;
  localparam logic [3:0] OFF_CNT_HI = 4'h5;
  localparam logic [3:0] OFF_CAP_LO = 4'h6;
  localparam logic [3:0] OFF_CAP_HI = 4'h7;
  localparam logic [3:0] OFF_CMPA_LO = 4'h8;
  localparam logic [3:0] OFF_CMPA_HI = 4'h9;
  localparam logic [3:0] OFF_CMPB_LO = 4'hA;
  localparam logic [3:0] OFF_CMPB_HI = 4'hB;
  localparam logic [3:0] OFF_IRQ_EN = 4'hC;
  localparam logic [3:0] OFF_FLAGS = 4'hD;
  // control A fields: compare output modes and low mode bits
  localparam int COM_A_LSB = 6;
  localparam int COM_B_LSB = 4;
  localparam int WGM_LO_LSB = 0;
  // control B fields
  localparam int FILT_EN_BIT = 7;
  localparam int EDGE_SEL_BIT = 6;
  localparam int WGM_HI_LSB = 3;
  localparam int CLK_SEL_LSB = 0;
  // force register, comparator control, flag and enable bits
  localparam int FORCE_A_BIT = 7;
  localparam int FORCE_B_BIT = 6;
  localparam int CMP_CAP_SEL_BIT = 6;
  localparam int CAP_BIT = 5;
  localparam int CMPB_BIT = 2;
  localparam int CMPA_BIT = 1;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // capture filter length in system clock samples
  localparam int FILT_LEN = 4;
  // waveform modes of note
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_CTC_A = 4'h4;
  localparam logic [3:0] WGM_PFC_CAP = 4'h8;
  localparam logic [3:0] WGM_PFC_A = 4'h9;
  localparam logic [3:0] WGM_PC_CAP = 4'hA;
  localparam logic [3:0] WGM_CTC_CAP = 4'hC;
  localparam logic [3:0] WGM_RSVD = 4'hD;
  localparam logic [3:0] WGM_FAST_CAP = 4'hE;
  // compare output actions
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
endpackage

// [testbench/tcc_counter_model.sv]
// Purpose: counter and prescaler standing beside the block
// Assumes: counts up only, wraps at 16'hFFFF
// Notes: a tick every TICK_DIV system clocks while run is high
module tcc_counter_model #(
  parameter int TICK_DIV = 4
) (
  input wire logic mclk, // system clock
  input wire logic rstn, // reset, active low
  input wire logic run, // counting enabled
  input wire logic count_wr, // load pulse
  input wire logic [15:0] count_wr_data, // load value
  output logic [15:0] count_value, // counter value
  output logic timer_tick, // timer clock pulse
  output logic count_at_top, // at maximum
  output logic count_at_bottom // at zero
);
  timeunit 1ns;
  timeprecision 1ps;
  int div_q;
  // prescaler and counter; a load beats counting
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      div_q <= 0;
      timer_tick <= 1'b0;
      count_value <= 16'h0000;
    end else begin
      timer_tick <= run && div_q == TICK_DIV - 1;
      div_q <= (run && div_q != TICK_DIV - 1) ? div_q + 1 : 0;
      if (count_wr) count_value <= count_wr_data;
      else if (timer_tick) count_value <= count_value + 16'h0001;
    end
  end
  assign count_at_top = count_value == 16'hFFFF;
  assign count_at_bottom = count_value == 16'h0000;
endmodule

// [testbench/tcc_monitor.sv]
// Purpose: port-level checks for the capture/compare block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the design top by the bind below
module tcc_monitor (
  input wire logic mclk, // system clock
  input wire logic rstn, // reset, active low
  input wire logic [3:0] reg_addr, // offset
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic [15:0] count_value, // counter value
  input wire logic timer_tick, // timer clock pulse
  input wire logic count_wr, // counter load
  input wire logic [15:0] count_wr_data, // load value
  input wire logic [1:0] compare_irq_ack, // compare acks
  input wire logic [1:0] compare_irq, // compare requests
  input wire logic [1:0] compare_match, // match pulses
  input wire logic [15:0] compare_top_a, // compare A value
  input wire logic [15:0] capture_top, // capture value
  input wire logic [3:0] wave_gen_mode, // waveform mode
  input wire logic [1:0] compare_out_mode_a // unit A mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic blk_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // a counter load arms the match block until the next timer tick
  always_ff @(posedge mclk) begin
    if (!rstn) blk_q <= 1'b0;
    else if (count_wr) blk_q <= !timer_tick;
    else if (timer_tick) blk_q <= 1'b0;
  end
  a_cnt_load: assert property (
    reg_wr && reg_addr == tcc_pkg::OFF_CNT_LO |=>
    count_wr && count_wr_data[7:0] == $past(reg_wdata))
    else $error("counter load missing or wrong");
  a_cnt_cause: assert property (
    count_wr |-> $past(reg_wr && reg_addr == tcc_pkg::OFF_CNT_LO))
    else $error("counter load without low byte write");
  a_latch_word: assert property (
    reg_wr && reg_addr == tcc_pkg::OFF_CNT_HI ##1 !reg_wr ##1
    reg_wr && reg_addr == tcc_pkg::OFF_CNT_LO |=>
    count_wr_data[15:8] == $past(reg_wdata, 3))
    else $error("counter high byte not from latch");
  a_match_block: assert property (
    timer_tick && (blk_q || count_wr) |=> compare_match == 2'h0)
    else $error("match not blocked after counter write");
  a_match_cause: assert property (
    compare_match[0] |-> $past(timer_tick && count_value == compare_top_a))
    else $error("compare A match without equality");
  a_ack_clear: assert property (
    compare_irq[0] && compare_irq_ack[0] ##1 !compare_match[0] |->
    !compare_irq[0])
    else $error("compare A request not cleared by ack");
  a_cap_read: assert property (
    reg_rd && reg_addr == tcc_pkg::OFF_CAP_LO ##1 !reg_rd && !reg_wr ##1
    reg_rd && reg_addr == tcc_pkg::OFF_CAP_HI |=>
    reg_rdata == $past(capture_top[15:8], 3))
    else $error("capture high read not from latch");
  a_cmp_read: assert property (
    reg_rd && reg_addr == tcc_pkg::OFF_CMPA_LO &&
    wave_gen_mode == tcc_pkg::WGM_NORMAL |=>
    reg_rdata == $past(compare_top_a[7:0]))
    else $error("compare A low read wrong");
  a_out_mode: assert property (
    reg_wr && reg_addr == tcc_pkg::OFF_CTRL_A |=>
    compare_out_mode_a == $past(reg_wdata[7:6]))
    else $error("output mode not applied at once");
  // main scenarios
  cover property (compare_match[0]);
  cover property ($rose(count_wr));
  cover property (timer_tick && blk_q);
endmodule
bind tcc_capture_compare tcc_monitor mon (
  .mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .count_value, .timer_tick, .count_wr, .count_wr_data,
  .compare_irq_ack, .compare_irq, .compare_match, .compare_top_a,
  .capture_top, .wave_gen_mode, .compare_out_mode_a);

// [testbench/testbench.sv]
// Purpose: register-level tests of the capture/compare block
// Assumes: counter stopped whenever exact capture values are needed
// Notes: reads sample data at the falling edge after the strobe
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic capture_in_pin = 1'b0, comparator_out = 1'b0;
  logic capture_irq_ack = 1'b0;
  logic [1:0] compare_irq_ack = 2'h0;
  logic [7:0] reg_rdata;
  logic [15:0] count_value, count_wr_data, compare_top_a, capture_top;
  logic timer_tick, count_at_top, count_at_bottom, count_wr, capture_irq;
  logic [1:0] compare_irq, compare_match, compare_out_state;
  logic [1:0] compare_out_mode_a, compare_out_mode_b;
  logic [3:0] wave_gen_mode;
  logic [2:0] clock_sel;
  int num_errors = 0, tests_run = 0, n0, n1;
  always #4 mclk = ~mclk;
  tcc_counter_model ctr (.mclk, .rstn, .run, .count_wr, .count_wr_data,
    .count_value, .timer_tick, .count_at_top, .count_at_bottom);
  tcc_capture_compare dut (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .count_value, .timer_tick, .count_at_top,
    .count_at_bottom, .count_wr, .count_wr_data, .capture_in_pin,
    .comparator_out, .capture_irq_ack, .compare_irq_ack, .capture_irq,
    .compare_irq, .compare_match, .compare_out_state, .compare_top_a,
    .capture_top, .wave_gen_mode, .clock_sel, .compare_out_mode_a,
    .compare_out_mode_b);
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] s, e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // bus cycles, each leaves the strobe low for one cycle after
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, string nm);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(nm, {8'h00, reg_rdata}, {8'h00, e});
  endtask
  task automatic cnt(input logic [15:0] v);
    wr(tcc_pkg::OFF_CNT_HI, v[15:8]);
    wr(tcc_pkg::OFF_CNT_LO, v[7:0]);
  endtask
  // bounded wait for capture (0) or compare A (1) request
  task automatic wait_irq(input int sel, output int n);
    n = 0;
    while ((sel == 0 ? capture_irq : compare_irq[0]) !== 1'b1) begin
      @(negedge mclk);
      n++;
      if (n > 200) begin
        num_errors++;
        complete_run();
      end
    end
  endtask
  task automatic edge_in(input int sel, input logic lvl, output int n);
    @(posedge mclk);
    if (sel == 0) capture_in_pin <= lvl;
    else comparator_out <= lvl;
    wait_irq(0, n);
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge mclk);
    @(negedge mclk);
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 16; i++) rd(4'(i), 8'h00, "reset read");
    cnt(16'h1234);
    rd(tcc_pkg::OFF_CNT_LO, 8'h34, "cnt lo");
    rd(tcc_pkg::OFF_CNT_HI, 8'h12, "cnt hi");
    wr(tcc_pkg::OFF_CMPA_HI, 8'hAB);
    rd(tcc_pkg::OFF_CNT_HI, 8'hAB, "latch");
    wr(tcc_pkg::OFF_CMPA_LO, 8'h20);
    rd(tcc_pkg::OFF_CMPA_HI, 8'hAB, "cmp hi");
    chk("top a", compare_top_a, 16'hAB20);
    wr(tcc_pkg::OFF_IRQ_EN, 8'h22);
    cnt(16'hAB10);
    @(posedge mclk) run <= 1'b1;
    wait_irq(1, n0);
    run <= 1'b0;
    rd(tcc_pkg::OFF_FLAGS, 8'h02, "flags");
    @(posedge mclk) compare_irq_ack <= 2'h1;
    @(posedge mclk) compare_irq_ack <= 2'h0;
    idle(2);
    chk("ack", {14'h0, compare_irq}, 16'h0);
    cnt(16'hAB20);
    @(posedge mclk) run <= 1'b1;
    repeat (40) @(posedge mclk);
    run <= 1'b0;
    idle(1);
    chk("block", {14'h0, compare_irq}, 16'h0);
    wr(tcc_pkg::OFF_CTRL_A, 8'h60);
    chk("mode", {14'h0, compare_out_mode_a}, 16'h1);
    chk("mode b", {14'h0, compare_out_mode_b}, 16'h2);
    wr(tcc_pkg::OFF_FORCE, 8'h80);
    idle(1);
    chk("force", {14'h0, compare_out_state}, 16'h1);
    rd(tcc_pkg::OFF_FLAGS, 8'h00, "force flag");
    wr(tcc_pkg::OFF_CTRL_B, 8'h08);
    idle(1);
    chk("keep", {14'h0, compare_out_state}, 16'h1);
    cnt(16'hFFFF);
    wr(tcc_pkg::OFF_CAP_LO, 8'hFF);
    chk("cap wr", capture_top, 16'h0000);
    wr(tcc_pkg::OFF_CTRL_B, 8'h40);
    cnt(16'h5678);
    edge_in(0, 1'b1, n0);
    rd(tcc_pkg::OFF_CAP_LO, 8'h78, "cap lo");
    rd(tcc_pkg::OFF_CAP_HI, 8'h56, "cap hi");
    @(posedge mclk) capture_irq_ack <= 1'b1;
    @(posedge mclk) capture_irq_ack <= 1'b0;
    idle(2);
    chk("cap ack", {15'h0, capture_irq}, 16'h0);
    cnt(16'h1111);
    @(posedge mclk) capture_in_pin <= 1'b0;
    idle(20);
    chk("fall", capture_top, 16'h5678);
    wr(tcc_pkg::OFF_CTRL_B, 8'hC0);
    edge_in(0, 1'b1, n1);
    chk("filter", n1[15:0], 16'(n0 + 4));
    chk("overwrite", capture_top, 16'h1111);
    wr(tcc_pkg::OFF_CTRL_B, 8'h80);
    wr(tcc_pkg::OFF_FLAGS, 8'h20);
    idle(1);
    chk("w1c", {15'h0, capture_irq}, 16'h0);
    cnt(16'h2222);
    edge_in(0, 1'b0, n1);
    chk("falling", capture_top, 16'h2222);
    wr(tcc_pkg::OFF_CMP_CTRL, 8'h40);
    wr(tcc_pkg::OFF_FLAGS, 8'h20);
    wr(tcc_pkg::OFF_CTRL_B, 8'h40);
    cnt(16'h3333);
    edge_in(1, 1'b1, n1);
    chk("comparator", capture_top, 16'h3333);
    wr(tcc_pkg::OFF_FLAGS, 8'h20);
    wr(tcc_pkg::OFF_CTRL_B, 8'h5A);
    chk("wgm", {12'h000, wave_gen_mode}, 16'h000C);
    chk("clk sel", {13'h0000, clock_sel}, 16'h0002);
    @(posedge mclk) comparator_out <= 1'b0;
    idle(10);
    @(posedge mclk) comparator_out <= 1'b1;
    idle(20);
    chk("top mode", {15'h0, capture_irq}, 16'h0);
    wr(tcc_pkg::OFF_CAP_HI, 8'h9A);
    wr(tcc_pkg::OFF_CAP_LO, 8'hBC);
    chk("cap top", capture_top, 16'h9ABC);
    // pwm mode 14: compare writes go to the buffer until TOP
    wr(tcc_pkg::OFF_CTRL_A, 8'h62);
    wr(tcc_pkg::OFF_CMPA_HI, 8'h12);
    wr(tcc_pkg::OFF_CMPA_LO, 8'h34);
    chk("buffered", compare_top_a, 16'hAB20);
    rd(tcc_pkg::OFF_CMPA_LO, 8'h34, "buf lo");
    wr(tcc_pkg::OFF_FORCE, 8'h80);
    idle(1);
    chk("pwm force", {14'h0, compare_out_state}, 16'h1);
    cnt(16'hFFFE);
    @(posedge mclk) run <= 1'b1;
    repeat (10) @(posedge mclk);
    run <= 1'b0;
    idle(2);
    chk("transfer", compare_top_a, 16'h1234);
    complete_run();
  end
endmodule
